// >>> csie_defs.vh
// What this block does
// - the 32 working registers answer at data addresses 0 to 31
// - registers 26..31 pair into three 16-bit pointers, odd one high
// - stack grows down; byte push decrements, byte pop increments by one
// - call or interrupt entry pushes two return bytes, pointer minus two
// - subroutine or interrupt return pops two bytes, pointer plus two
// - stack pointer is two 8-bit I/O registers resetting to top of SRAM
// - interrupt taken only with its own enable and global enable set
// - lower vector wins; reset first, external request zero next
// - entry clears global enable; handler may set it again to nest
// - taking a flag interrupt vectors the PC and clears that flag
// - writing one to a flag bit clears it; zero leaves it alone
// - flags raised while disabled stay pending, then serve by priority
// - level sources request only while their condition is present
// - after interrupt return one main instruction runs before another entry
// - status register is neither saved nor restored by hardware
// - global clear acts at once, even on a request in the same cycle
// - after global set, the following instruction runs before any entry
// - entry takes four cycles pushing the PC, and loads the vector into the PC in the fourth
// - a multi-cycle instruction finishes before entry begins
// - wake from sleep adds four cycles to the entry response
// - interrupt return takes four cycles, pops PC, SP plus two, sets enable
// - global interrupt enable is bit 7 of the status register
`ifndef CSIE_DEFS_VH
`define CSIE_DEFS_VH
`define CSIE_NSRC 8
`define CSIE_DS_IO_BASE 16'h0020
`define CSIE_PTR_A_LO 5'h1a
`define CSIE_PTR_B_LO 5'h1c
`define CSIE_PTR_C_LO 5'h1e
`define CSIE_IO_FLAG 6'h3b
`define CSIE_IO_EN 6'h3c
`define CSIE_IO_SPL 6'h3d
`define CSIE_IO_SPH 6'h3e
`define CSIE_IO_CPU_FLAGS_REG 6'h3f
`define CSIE_LAST_SRAM 16'h02ff
`define CSIE_CPU_FLAGS_REG_RST 8'h00
`define CSIE_FLAG_RST 8'h00
`define CSIE_EN_RST 8'h00
`define CSIE_GIE_BIT 7
`define CSIE_ENTRY_CYC 4'h4
`define CSIE_SLEEP_CYC 4'h4
`define CSIE_IRQ_EXIT_OP_CYC 4'h4
`endif

// >>> csie_prio.v
`timescale 1ns/1ps
module csie_prio (
	req,
	any,
	idx
);
	input wire [7:0] req;
	output reg any;
	output reg [2:0] idx;
	integer i;
	// lowest index has the lowest vector address and so wins
	always @* begin
		any = 1'b0;
		idx = 3'h0;
		for (i = 7; i >= 0; i = i - 1) begin
			if (req[i]) begin
				any = 1'b1;
				idx = i[2:0];
			end
		end
	end
endmodule

// >>> csie_core.v
`timescale 1ns/1ps
`include "csie_defs.vh"
module csie_core #(
	parameter [7:0] LEVEL_SRC = 8'h00,
	parameter [15:0] VEC_STRIDE = 16'h0002,
	parameter [15:0] LAST_SRAM = `CSIE_LAST_SRAM
) (
	input wire mclk,
	input wire sys_rst,
	input wire [7:0] srcEvent,
	input wire [7:0] srcLevel,
	input wire instBoundary,
	input wire sleeping,
	input wire opPush,
	input wire opPop,
	input wire opCall,
	input wire opRet,
	input wire opReti,
	input wire opCli,
	input wire opSei,
	input wire [7:0] pushData,
	input wire [15:0] pcIn,
	input wire rfWe,
	input wire [4:0] rfWaddr,
	input wire [7:0] rfWdata,
	input wire [4:0] rfRaddr,
	output reg [7:0] rfRdataQ,
	input wire ptrStep,
	input wire [1:0] ptrSel,
	input wire ptrDown,
	output wire [15:0] ptrA,
	output wire [15:0] ptrB,
	output wire [15:0] ptrC,
	input wire dsWe,
	input wire dsRe,
	input wire [15:0] dsAddr,
	input wire [7:0] dsWdata,
	output reg [7:0] dsRdataQ,
	output reg dsHitQ,
	input wire ioWe,
	input wire ioRe,
	input wire [5:0] ioAddr,
	input wire [7:0] ioWdata,
	output reg [7:0] ioRdataQ,
	output reg memWeQ,
	output reg memReQ,
	output reg [15:0] memAddrQ,
	output reg [7:0] memWdataQ,
	input wire [7:0] memRdata,
	output reg pcLoadQ,
	output reg [15:0] pcNewQ,
	output reg seqDoneQ,
	output reg busyQ,
	output reg irqTakenQ,
	output reg irqPendQ,
	output reg gieQ
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_PUSH = 2'h1;
	localparam [1:0] ST_POP = 2'h2;

	reg [7:0] rf [0:31];
	reg [15:0] spQ, spD;
	reg [7:0] sregQ, sregD;
	reg [7:0] flagQ, flagD;
	reg [7:0] enQ, enD;
	reg [1:0] stQ, stD;
	reg [3:0] cntQ, cntD;
	reg irqKindQ, irqKindD;
	reg [15:0] pcSaveQ, pcSaveD;
	reg [7:0] hiQ, hiD;
	reg [2:0] vecIdxQ, vecIdxD;
	reg memWeD, memReD, pcLoadD, seqDoneD, irqTakenD;
	reg [15:0] memAddrD, pcNewD;
	reg [7:0] memWdataD;

	// add or subtract a small step on a 16-bit pointer
	function [15:0] step16;
		input [15:0] v;
		input down;
		input [1:0] n;
		begin
			if (down)
				step16 = v - {14'h0000, n};
			else
				step16 = v + {14'h0000, n};
		end
	endfunction

	wire [7:0] reqVec;
	wire [7:0] armed;
	wire anyReq;
	wire [2:0] pickIdx;
	wire take;
	wire [4:0] ptrLo;
	wire [4:0] ptrHi;
	wire [15:0] ptrCur;
	wire [15:0] ptrNext;
	wire dsInRf;

	// level sources bypass the flag and vanish with their condition
	assign reqVec = (LEVEL_SRC & srcLevel) | (~LEVEL_SRC & flagQ);
	assign armed = reqVec & enQ;

	csie_prio u_prio (
		.req(armed),
		.any(anyReq),
		.idx(pickIdx)
	);

	// only at an instruction end, never during a sequence, and the old
	// enable is used so a same-cycle set still lets the next instruction run
	assign take = (stQ == ST_IDLE) & instBoundary & anyReq
		& sregQ[`CSIE_GIE_BIT]
		& ~opCli;

	assign ptrLo = `CSIE_PTR_A_LO + {2'b00, ptrSel, 1'b0};
	assign ptrHi = ptrLo + 5'h01;
	assign ptrCur = {rf[ptrHi], rf[ptrLo]};
	assign ptrNext = step16(ptrCur, ptrDown, 2'h1);
	assign ptrA = {rf[`CSIE_PTR_A_LO + 5'h01], rf[`CSIE_PTR_A_LO]};
	assign ptrB = {rf[`CSIE_PTR_B_LO + 5'h01], rf[`CSIE_PTR_B_LO]};
	assign ptrC = {rf[`CSIE_PTR_C_LO + 5'h01], rf[`CSIE_PTR_C_LO]};
	assign dsInRf = (dsAddr < `CSIE_DS_IO_BASE);

	always @(posedge mclk) begin
		if (rfWe)
			rf[rfWaddr] <= rfWdata;
		if (dsWe && dsInRf)
			rf[dsAddr[4:0]] <= dsWdata;
		if (ptrStep) begin
			rf[ptrLo] <= ptrNext[7:0];
			rf[ptrHi] <= ptrNext[15:8];
		end
		rfRdataQ <= rf[rfRaddr];
		dsRdataQ <= (dsRe && dsInRf) ? rf[dsAddr[4:0]] : 8'h00;
	end

	always @* begin
		spD = spQ;
		sregD = sregQ;
		flagD = flagQ;
		enD = enQ;
		stD = stQ;
		cntD = cntQ;
		irqKindD = irqKindQ;
		pcSaveD = pcSaveQ;
		hiD = hiQ;
		vecIdxD = vecIdxQ;
		memWeD = 1'b0;
		memReD = 1'b0;
		memAddrD = memAddrQ;
		memWdataD = memWdataQ;
		pcLoadD = 1'b0;
		pcNewD = pcNewQ;
		seqDoneD = 1'b0;
		irqTakenD = 1'b0;

		if (ioWe) begin
			case (ioAddr)
				`CSIE_IO_SPL: spD[7:0] = ioWdata;
				`CSIE_IO_SPH: spD[15:8] = ioWdata;
				`CSIE_IO_CPU_FLAGS_REG: sregD = ioWdata;
				`CSIE_IO_FLAG: flagD = flagQ & ~ioWdata;
				`CSIE_IO_EN: enD = ioWdata;
				default: spD = spD;
			endcase
		end
		if (opCli)
			sregD[`CSIE_GIE_BIT] = 1'b0;
		if (opSei)
			sregD[`CSIE_GIE_BIT] = 1'b1;

		case (stQ)
			ST_IDLE: begin
				if (take) begin
					// only the I bit changes; other status bits are the
					// handler's to save
					sregD[`CSIE_GIE_BIT] = 1'b0;
					if (!LEVEL_SRC[pickIdx])
						flagD[pickIdx] = 1'b0;
					vecIdxD = pickIdx;
					pcSaveD = pcIn;
					irqKindD = 1'b1;
					irqTakenD = 1'b1;
					stD = ST_PUSH;
					if (sleeping)
						cntD = `CSIE_ENTRY_CYC + `CSIE_SLEEP_CYC - 4'h1;
					else
						cntD = `CSIE_ENTRY_CYC - 4'h1;
				end else if (opCall) begin
					pcSaveD = pcIn;
					irqKindD = 1'b0;
					stD = ST_PUSH;
					cntD = `CSIE_ENTRY_CYC - 4'h1;
				end else if (opRet || opReti) begin
					irqKindD = opReti;
					stD = ST_POP;
					cntD = `CSIE_IRQ_EXIT_OP_CYC - 4'h1;
				end else if (opPush) begin
					memWeD = 1'b1;
					memAddrD = spQ;
					memWdataD = pushData;
					spD = step16(spQ, 1'b1, 2'h1);
				end else if (opPop) begin
					memReD = 1'b1;
					memAddrD = step16(spQ, 1'b0, 2'h1);
					spD = step16(spQ, 1'b0, 2'h1);
				end
			end
			ST_PUSH: begin
				cntD = cntQ - 4'h1;
				if (cntQ == 4'h3) begin
					memWeD = 1'b1;
					memAddrD = spQ;
					memWdataD = pcSaveQ[7:0];
				end
				if (cntQ == 4'h2) begin
					memWeD = 1'b1;
					memAddrD = step16(spQ, 1'b1, 2'h1);
					memWdataD = pcSaveQ[15:8];
					spD = step16(spQ, 1'b1, 2'h2);
				end
				if (cntQ == 4'h0) begin
					stD = ST_IDLE;
					seqDoneD = 1'b1;
					if (irqKindQ) begin
						pcLoadD = 1'b1;
						pcNewD = ({13'h0000, vecIdxQ} + 16'h0001) * VEC_STRIDE;
					end
				end
			end
			ST_POP: begin
				cntD = cntQ - 4'h1;
				if (cntQ == 4'h3) begin
					memReD = 1'b1;
					memAddrD = step16(spQ, 1'b0, 2'h1);
				end
				if (cntQ == 4'h2) begin
					memReD = 1'b1;
					memAddrD = step16(spQ, 1'b0, 2'h2);
					spD = step16(spQ, 1'b0, 2'h2);
				end
				if (cntQ == 4'h1)
					hiD = memRdata;
				if (cntQ == 4'h0) begin
					// the sequencer resumes at this PC and must finish that
					// instruction before the next boundary can take
					stD = ST_IDLE;
					seqDoneD = 1'b1;
					pcLoadD = 1'b1;
					pcNewD = {hiQ, memRdata};
					if (irqKindQ)
						sregD[`CSIE_GIE_BIT] = 1'b1;
				end
			end
			default: stD = ST_IDLE;
		endcase

		// a new event wins over any clear in the same cycle
		flagD = flagD | (srcEvent & ~LEVEL_SRC);
	end

	always @(posedge mclk) begin
		if (sys_rst) begin
			spQ <= LAST_SRAM;
			sregQ <= `CSIE_CPU_FLAGS_REG_RST;
			flagQ <= `CSIE_FLAG_RST;
			enQ <= `CSIE_EN_RST;
			stQ <= ST_IDLE;
			cntQ <= 4'h0;
			irqKindQ <= 1'b0;
			pcSaveQ <= 16'h0000;
			hiQ <= 8'h00;
			vecIdxQ <= 3'h0;
			memWeQ <= 1'b0;
			memReQ <= 1'b0;
			memAddrQ <= 16'h0000;
			memWdataQ <= 8'h00;
			pcLoadQ <= 1'b0;
			pcNewQ <= 16'h0000;
			seqDoneQ <= 1'b0;
			busyQ <= 1'b0;
			irqTakenQ <= 1'b0;
			irqPendQ <= 1'b0;
			gieQ <= 1'b0;
			ioRdataQ <= 8'h00;
			dsHitQ <= 1'b0;
		end else begin
			spQ <= spD;
			sregQ <= sregD;
			flagQ <= flagD;
			enQ <= enD;
			stQ <= stD;
			cntQ <= cntD;
			irqKindQ <= irqKindD;
			pcSaveQ <= pcSaveD;
			hiQ <= hiD;
			vecIdxQ <= vecIdxD;
			memWeQ <= memWeD;
			memReQ <= memReD;
			memAddrQ <= memAddrD;
			memWdataQ <= memWdataD;
			pcLoadQ <= pcLoadD;
			pcNewQ <= pcNewD;
			seqDoneQ <= seqDoneD;
			busyQ <= (stD != ST_IDLE);
			irqTakenQ <= irqTakenD;
			// enabled request regardless of global enable, used to wake
			irqPendQ <= |armed;
			gieQ <= sregD[`CSIE_GIE_BIT];
			dsHitQ <= dsRe & dsInRf;
			if (ioRe) begin
				case (ioAddr)
					`CSIE_IO_SPL: ioRdataQ <= spQ[7:0];
					`CSIE_IO_SPH: ioRdataQ <= spQ[15:8];
					`CSIE_IO_CPU_FLAGS_REG: ioRdataQ <= sregQ;
					`CSIE_IO_FLAG: ioRdataQ <= reqVec;
					`CSIE_IO_EN: ioRdataQ <= enQ;
					default: ioRdataQ <= 8'h00;
				endcase
			end else begin
				ioRdataQ <= 8'h00;
			end
		end
	end
endmodule

// >>> csie_stack_mem.sv
`timescale 1ns/1ps
module csie_stack_mem (
	input logic mclk,
	input logic we,
	input logic re,
	input logic [15:0] addr,
	input logic [7:0] wdata,
	output logic [7:0] rdata = 8'h00
);
	logic [7:0] mem [0:1023];
	// read data lasts one cycle, then inverts on every cycle that re stays low
	always @(posedge mclk) begin
		if (we)
			mem[addr[9:0]] <= wdata;
		rdata <= re ? mem[addr[9:0]] : ~rdata;
	end
endmodule

// >>> csie_core_sva.sv
`timescale 1ns/1ps
module csie_core_sva (
	input logic mclk,
	input logic sys_rst,
	input logic opPush,
	input logic opReti,
	input logic opCli,
	input logic opSei,
	input logic [7:0] pushData,
	input logic busyQ,
	input logic irqTakenQ,
	input logic gieQ,
	input logic memWeQ,
	input logic memReQ,
	input logic [15:0] memAddrQ,
	input logic [7:0] memWdataQ,
	input logic pcLoadQ,
	input logic seqDoneQ
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_push; !busyQ && opPush |=> memWeQ && memWdataQ == $past(pushData);
	endproperty
	a_push: assert property (p_push) else $error("push lost");
	property p_ent; irqTakenQ ##1 memWeQ |=> memWeQ &&
		memAddrQ == $past(memAddrQ) - 16'h0001; endproperty
	a_ent: assert property (p_ent) else $error("entry push");
	property p_pop; memReQ ##1 memReQ |-> memAddrQ == $past(memAddrQ) + 16'h0001;
	endproperty
	a_pop: assert property (p_pop) else $error("pop order");
	property p_gie; irqTakenQ |-> $past(gieQ); endproperty
	a_gie: assert property (p_gie) else $error("taken masked");
	property p_clr; irqTakenQ |-> !gieQ; endproperty
	a_clr: assert property (p_clr) else $error("enable kept");
	property p_cli; opCli |=> !irqTakenQ; endproperty
	a_cli: assert property (p_cli) else $error("taken after clear");
	property p_sei; opSei && !gieQ |=> !irqTakenQ; endproperty
	a_sei: assert property (p_sei) else $error("taken after set");
	property p_len; irqTakenQ |-> ##[4:8] (pcLoadQ && seqDoneQ); endproperty
	a_len: assert property (p_len) else $error("entry length");
	property p_irq_exit_op; !busyQ && opReti |-> ##5 (pcLoadQ && gieQ); endproperty
	a_irq_exit_op: assert property (p_irq_exit_op) else $error("return seq");
endmodule
bind csie_core csie_core_sva i_csie_core_sva (.mclk, .sys_rst, .opPush,
	.opReti, .opCli, .opSei, .pushData, .busyQ, .irqTakenQ, .gieQ, .memWeQ,
	.memReQ, .memAddrQ, .memWdataQ, .pcLoadQ, .seqDoneQ);

// >>> csie_core_tb_top.sv
`timescale 1ns/1ps
module csie_core_tb_top;
	logic mclk = 0;
	logic sys_rst = 1;
	// sleep, boundary, push, pop, call, ret, irq_exit_op, cli, sei
	logic [8:0] ctl = 0;
	logic [7:0] ev = 0, lvl = 0, pushData = 0, ioWdata = 0, rfWdata = 0;
	logic [7:0] dsWdata = 0;
	logic [15:0] pcIn = 0, dsAddr = 0, pcGot, loadAt;
	logic ioWe = 0, ioRe = 0, rfWe = 0, dsRe = 0, ptrStep = 0, took;
	logic dsWe = 0, ptrDown = 0;
	logic [1:0] ptrSel = 0;
	logic [5:0] ioAddr = 0;
	logic [4:0] rfWaddr = 0;
	logic [7:0] rfRdataQ, dsRdataQ, ioRdataQ, memWdataQ, memRdata;
	logic [15:0] ptrA, ptrB, ptrC, memAddrQ, pcNewQ;
	logic dsHitQ, memWeQ, memReQ, pcLoadQ, seqDoneQ, busyQ, irqTakenQ;
	logic irqPendQ, gieQ;
	int err_count = 0, checks = 0, cycles = 0;
	always #4 mclk = ~mclk;
	csie_core #(.LEVEL_SRC(8'h80)) i_csie_core (.mclk, .sys_rst,
		.srcEvent(ev), .srcLevel(lvl), .instBoundary(ctl[7]),
		.sleeping(ctl[8]), .opPush(ctl[6]), .opPop(ctl[5]), .opCall(ctl[4]),
		.opRet(ctl[3]), .opReti(ctl[2]), .opCli(ctl[1]), .opSei(ctl[0]),
		.pushData, .pcIn, .rfWe, .rfWaddr, .rfWdata, .rfRaddr(rfWaddr),
		.rfRdataQ, .ptrStep, .ptrSel, .ptrDown, .ptrA, .ptrB,
		.ptrC, .dsWe, .dsRe, .dsAddr, .dsWdata, .dsRdataQ,
		.dsHitQ, .ioWe, .ioRe, .ioAddr, .ioWdata, .ioRdataQ, .memWeQ,
		.memReQ, .memAddrQ, .memWdataQ, .memRdata, .pcLoadQ, .pcNewQ,
		.seqDoneQ, .busyQ, .irqTakenQ, .irqPendQ, .gieQ);
	csie_stack_mem i_csie_stack_mem (.mclk, .we(memWeQ), .re(memReQ),
		.addr(memAddrQ), .wdata(memWdataQ), .rdata(memRdata));
	task chk(input [15:0] got, input [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// a read compares the answer against d
	task io(input w, input [5:0] a, input [7:0] d);
		@(posedge mclk);
		ioWe <= w;
		ioRe <= !w;
		ioAddr <= a;
		ioWdata <= d;
		@(posedge mclk);
		ioWe <= 0;
		ioRe <= 0;
		@(negedge mclk);
		if (!w)
			chk(ioRdataQ, d);
	endtask
	task pulse(input [8:0] v, input [7:0] e);
		@(posedge mclk);
		ctl <= v;
		ev <= e;
		@(posedge mclk);
		ctl <= 0;
		ev <= 0;
	endtask
	task seq(input [8:0] v);
		pulse(v, 8'h00);
		took = 0;
		pcGot = 0;
		loadAt = 0;
		// loadAt counts falling edges from the op edge to the PC load
		for (int n = 1; n <= 12; n++) begin
			@(negedge mclk);
			if (irqTakenQ)
				took = 1;
			if (pcLoadQ) begin
				pcGot = pcNewQ;
				loadAt = 16'(n);
			end
		end
	endtask
	task rfw(input [4:0] a, input [7:0] d);
		@(posedge mclk);
		rfWe <= 1;
		rfWaddr <= a;
		rfWdata <= d;
		@(posedge mclk);
		rfWe <= 0;
	endtask
	task tally_and_finish;
		$display("mismatches %0d comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 0;
		pushData <= 8'h5a;
		pcIn <= 16'h1234;
		io(0, 6'h3d, 8'hff);
		io(0, 6'h3e, 8'h02);
		io(0, 6'h10, 8'h00);
		io(1, 6'h3d, 8'h80);
		io(0, 6'h3d, 8'h80);
		seq(9'h040);
		io(0, 6'h3d, 8'h7f);
		seq(9'h020);
		io(0, 6'h3d, 8'h80);
		seq(9'h010);
		io(0, 6'h3d, 8'h7e);
		seq(9'h008);
		chk(pcGot, 16'h1234);
		for (int i = 0; i < 3; i++) begin
			rfw(5'(26 + 2 * i), 8'(8'hff - i));
			rfw(5'(27 + 2 * i), 8'(8'h20 + i));
		end
		@(negedge mclk);
		chk(ptrA, 16'h20ff);
		chk(ptrB, 16'h21fe);
		chk(ptrC, 16'h22fd);
		@(posedge mclk);
		dsRe <= 1;
		dsAddr <= 16'h001b;
		ptrStep <= 1;
		@(posedge mclk);
		dsRe <= 0;
		ptrStep <= 0;
		@(negedge mclk);
		chk(dsRdataQ, 8'h20);
		chk(dsHitQ, 1);
		chk(ptrA, 16'h2100);
		chk(rfRdataQ, 8'h22);
		@(posedge mclk);
		dsWe <= 1;
		dsAddr <= 16'h001d;
		dsWdata <= 8'h33;
		ptrStep <= 1;
		ptrSel <= 2'h2;
		ptrDown <= 1;
		@(posedge mclk);
		dsWe <= 0;
		ptrStep <= 0;
		@(negedge mclk);
		chk(ptrB, 16'h33fe);
		chk(ptrC, 16'h22fc);
		io(1, 6'h3c, 8'h8a);
		pulse(0, 8'h0b);
		io(0, 6'h3b, 8'h0b);
		chk(irqPendQ, 1);
		io(1, 6'h3b, 8'h01);
		io(1, 6'h3b, 8'h00);
		io(0, 6'h3b, 8'h0a);
		seq(9'h080);
		chk(took, 0);
		seq(9'h081);
		chk(took, 0);
		io(0, 6'h3f, 8'h80);
		io(1, 6'h3f, 8'h85);
		seq(9'h080);
		chk(took, 1);
		chk(pcGot, 16'h0004);
		chk(loadAt, 16'h0005);
		chk(gieQ, 0);
		io(0, 6'h3f, 8'h05);
		io(0, 6'h3b, 8'h08);
		io(0, 6'h3d, 8'h7e);
		seq(9'h004);
		chk(pcGot, 16'h1234);
		chk(gieQ, 1);
		chk(loadAt, 16'h0005);
		chk(took, 0);
		io(0, 6'h3f, 8'h85);
		io(0, 6'h3d, 8'h80);
		seq(9'h082);
		chk(took, 0);
		seq(9'h001);
		seq(9'h180);
		chk(pcGot, 16'h0008);
		chk(loadAt, 16'h0009);
		@(posedge mclk);
		lvl <= 8'h80;
		io(0, 6'h3b, 8'h80);
		@(posedge mclk);
		lvl <= 8'h00;
		seq(9'h001);
		seq(9'h080);
		chk(took, 0);
		chk(irqPendQ, 0);
		tally_and_finish;
	end
endmodule
